// [test/sbp_base_regs_test.sv]
module sbp_base_regs_test;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel, penable, pwrite, pready, pslverr, status_push, bus_reset_active;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic bus_reset_in = 1'h0, link_busy = 1'h0, self_id_done = 1'h0, became_root = 1'h0;
	logic cable_power_sense = 1'h1, contender_link_on_pin = 1'h1, link_power_status = 1'h1;
	logic phy_config_valid = 1'h0, port_event = 1'h0;
	logic [5:0] self_id_address = 6'h0, phy_config_gap = 6'h0;
	logic [2:0] power_class_pins = 3'h5;
	logic [7:0] paged_rdata = 8'ha5;
	logic [3:0] ro_i [4] = '{4'h0, 4'h2, 4'h3, 4'h6};
	logic [7:0] ro_x [4] = '{8'h01, 8'he3, 8'h40, 8'h00};
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;

	always #25 pclk = ~pclk;

	sbp_base_regs DUT (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .bus_reset_in, .link_busy, .self_id_done, .self_id_address,
		.became_root, .cable_power_sense, .contender_link_on_pin, .power_class_pins,
		.link_power_status, .phy_config_valid, .phy_config_gap, .port_event, .paged_rdata,
		.config_timeout_event(1'h0), .state_timeout_event(1'h0), .resume_event(1'h0),
		.paged_index(), .paged_write(), .paged_wdata(), .page_choice(), .port_choice(),
		.node_address_valid(), .status_push, .root_holdoff(), .bus_reset_active,
		.arb_gap_setting(), .arb_accel_enable(), .multispeed_enable(),
		.self_id_link_bit(), .self_id_contender(), .self_id_power_class()
	);

	sbp_link_model llc (
		.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		if (error_cnt == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] i, input logic [7:0] d);
		logic [7:0] q;
		logic e;
		llc.xfer(1'h1, {2'h0, i, 2'h0}, d, q, e);
	endtask

	// Mask lets a check skip bits whose value is not pinned down
	task automatic rd(input logic [3:0] i, input logic [7:0] x, input logic [7:0] m = 8'hff);
		logic [7:0] q;
		logic e;
		llc.xfer(1'h0, {2'h0, i, 2'h0}, 8'h0, q, e);
		chk(q & m, x, "read");
	endtask

	task automatic bus_rst();
		bus_reset_in <= 1'h1;
		@(posedge pclk);
		bus_reset_in <= 1'h0;
		repeat (3) @(posedge pclk);
	endtask

	// Hang guard, well above the long bus reset plus all transfers
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 12000)
		begin
			error_cnt++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		int n;
		int p;
		logic [7:0] q;
		logic e;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		repeat (2) @(posedge pclk);
		rd(4'h1, 8'h3f);
		rd(4'h4, 8'hc5);
		rd(4'h5, 8'h00);
		rd(4'h7, 8'h00);
		// Read-only and reserved places keep their values under writes
		for (p = 0; p < 4; p++)
		begin
			wr(ro_i[p], 8'hff);
			rd(ro_i[p], ro_x[p]);
		end
		cable_power_sense <= 1'h0;
		rd(4'h0, 8'h00);
		rd(4'h5, 8'h10);
		// Ones on every flag place, so each write-one clear path is driven
		wr(4'h5, 8'h3c);
		rd(4'h5, 8'h00);
		cable_power_sense <= 1'h1;
		self_id_address <= 6'h2a;
		self_id_done <= 1'h1;
		became_root <= 1'h1;
		@(posedge pclk);
		self_id_done <= 1'h0;
		became_root <= 1'h0;
		@(negedge pclk);
		chk({7'h0, status_push}, 8'h1, "push");
		@(posedge pclk);
		rd(4'h0, 8'hab);
		// Traffic busy holds the long reset request off until a bus reset clears it
		link_busy <= 1'h1;
		wr(4'h1, 8'hc5);
		wr(4'h4, 8'h40);
		wr(4'h7, 8'h62);
		bus_rst();
		rd(4'h0, 8'h00, 8'h02);
		rd(4'h1, 8'h85);
		phy_config_gap <= 6'h0a;
		phy_config_valid <= 1'h1;
		@(posedge pclk);
		phy_config_valid <= 1'h0;
		rd(4'h1, 8'h8a);
		bus_rst();
		rd(4'h1, 8'h8a);
		bus_rst();
		rd(4'h1, 8'hbf);
		rd(4'h4, 8'h40);
		rd(4'h7, 8'h62);
		// Long reset launches only once traffic ends
		wr(4'h1, 8'h40);
		rd(4'h1, 8'h40, 8'h40);
		@(negedge pclk);
		chk({7'h0, bus_reset_active}, 8'h0, "held");
		@(posedge pclk);
		link_busy <= 1'h0;
		n = 0;
		while (bus_reset_active !== 1'h1 && n < 10)
		begin
			@(negedge pclk);
			n++;
		end
		chk({7'h0, bus_reset_active}, 8'h1, "launch");
		n = 0;
		while (bus_reset_active === 1'h1 && n < 4000)
		begin
			@(negedge pclk);
			n++;
		end
		chk({7'h0, n == 166000 / 50}, 8'h1, "length");
		@(posedge pclk);
		rd(4'h1, 8'h00, 8'h40);
		// Upper addresses follow the selected page
		for (p = 0; p < 8; p++)
		begin
			wr(4'h7, 8'(p << 5));
			rd(4'(8 + p), (p >= 2 && p <= 6) ? 8'h00 : 8'ha5);
		end
		port_event <= 1'h1;
		@(posedge pclk);
		port_event <= 1'h0;
		rd(4'h5, 8'h04, 8'h3c);
		wr(4'h5, 8'h04);
		rd(4'h5, 8'h00, 8'h3c);
		llc.xfer(1'h0, 8'h41, 8'h0, q, e);
		chk({7'h0, e}, 8'h1, "error");
		wrap_up();
	end
endmodule

// [test/sbp_link_model.sv]
// ------------------------------------------------------------
// Link-layer controller model: APB master toward the PHY bank
// ------------------------------------------------------------
module sbp_link_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ns;

	// Bus idle from time zero
	initial
	begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end

	// One transfer; entered and left just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic e);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		// No fixed latency assumed; the bench timeout ends a hang
		while (pready !== 1'h1)
			@(posedge pclk);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Idle edge so a following setup never shares a step with this release
		@(posedge pclk);
	endtask
endmodule

// [verilog/sbp_base_regs.sv]
// Notes on behaviour
// [R1] Sixteen addresses; upper eight follow selected page
// [R2] Page held in register 7; base fixed
// [R3] Reserved bits and registers read zero
// [R4] Pages two through six read zero
// [R5] Node address from self-ID; status push
// [R6] Root flag cleared by bus reset
// [R7] Cable power bit follows sense input
// [R8] Root holdoff kept across bus reset
// [R9] Long reset waits for traffic; 166 us
// [R10] Long reset request clears on resets
// [R11] Gap setting by write or packet
// [R12] Gap back to 3Fh on the second bus reset without an update
// [R13] Extended set code reads 111b
// [R14] Port quantity reads three
// [R15] Speed capability reads 010b
// [R16] Repeater delay field reads zero
// [R17] Bound-up set at reset; ANDed out
// [R18] Manager bid strapped from pin
// [R19] Repeater jitter field reads zero
// [R20] Page choice cleared only by reset
// [R21] Port choice cleared only by reset
// [R22] Interrupt flags clear by writing one
// [R23] Writes to read-only fields ignored
//
// The APB slave port is this design's own decision.
module sbp_base_regs #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_reset_in,
	input wire logic link_busy,
	input wire logic self_id_done,
	input wire logic [5:0] self_id_address,
	input wire logic became_root,
	input wire logic cable_power_sense,
	input wire logic contender_link_on_pin,
	input wire logic [2:0] power_class_pins,
	input wire logic link_power_status,
	input wire logic phy_config_valid,
	input wire logic [5:0] phy_config_gap,
	input wire logic config_timeout_event,
	input wire logic state_timeout_event,
	input wire logic port_event,
	input wire logic resume_event,
	input wire logic [7:0] paged_rdata,
	output logic [2:0] paged_index,
	output logic paged_write,
	output logic [7:0] paged_wdata,
	output logic [2:0] page_choice,
	output logic [3:0] port_choice,
	output logic node_address_valid,
	output logic status_push,
	output logic root_holdoff,
	output logic bus_reset_active,
	output logic [5:0] arb_gap_setting,
	output logic arb_accel_enable,
	output logic multispeed_enable,
	output logic self_id_link_bit,
	output logic self_id_contender,
	output logic [2:0] self_id_power_class
);
	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	generate
		if (ADDR_W < 6)
		begin : g_bad
			$error("Address bus must reach sixteen words");
		end
	endgenerate

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [5:0] node_address;
		logic addr_valid;
		logic top_node;
		logic cable_power_status;
		logic root_holdoff;
		logic long_req;
		logic short_req;
		logic bound_up;
		logic bid;
		logic [2:0] pwr;
		logic straps_taken;
		logic rpie;
		logic ctoi;
		logic cpsi;
		logic stoi;
		logic pei;
		logic eaa;
		logic emc;
		logic [2:0] page;
		logic [3:0] port;
		logic status_push;
		logic link_bit;
		logic [7:0] rdata;
		logic slverr;
	} sbp_state_t;

	sbp_state_t cur;
	sbp_state_t next_cur;

	logic [3:0] idx;
	logic mapped;
	logic setup;
	logic wr_ok;
	logic wr_gap;
	logic wr_link;
	logic wr_irq;
	logic wr_page;
	logic upper_rsvd;
	logic launch_long;
	logic launch_short;
	logic bus_reset_ev;
	logic timer_active;
	logic [7:0] rd;

	// Pages two to six hold nothing
	function automatic logic page_reserved(input logic [2:0] pg);
		return (pg >= sbp_pkg::RSVD_PAGE_LO) && (pg <= sbp_pkg::RSVD_PAGE_HI);
	endfunction

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// One word per register; anything off the sixteen words is an error
	assign idx = paddr[5:2]; // [R1]
	assign mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:6] == '0);
	assign setup = psel && !penable;
	assign wr_ok = psel && penable && pwrite && mapped && pstrb[0];
	assign wr_gap = wr_ok && (idx == sbp_pkg::IDX_GAP);
	assign wr_link = wr_ok && (idx == sbp_pkg::IDX_LINK);
	assign wr_irq = wr_ok && (idx == sbp_pkg::IDX_IRQ);
	assign wr_page = wr_ok && (idx == sbp_pkg::IDX_PAGE);
	assign upper_rsvd = idx[3] && page_reserved(cur.page); // [R4]

	// Paged space is served outside; reserved pages are never passed on
	assign paged_index = idx[2:0];
	assign paged_write = wr_ok && idx[3] && !page_reserved(cur.page); // [R1]
	assign paged_wdata = pwdata[7:0];

	// ------------------------------------------------------------
	// Bus reset launch
	// ------------------------------------------------------------
	// Never cut into a packet; the long request has priority
	assign launch_long = cur.long_req && !link_busy && !timer_active; // [R9]
	assign launch_short = cur.short_req && !cur.long_req && !link_busy && !timer_active;
	assign bus_reset_ev = bus_reset_in || launch_long || launch_short;

	sbp_reset_timer #(
		.LONG_CYCLES(sbp_pkg::LONG_RESET_CYCLES),
		.SHORT_CYCLES(sbp_pkg::SHORT_RESET_CYCLES)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start_long(launch_long),
		.start_short(launch_short),
		.active(timer_active)
	);

	sbp_gap_tracker u_gap (
		.pclk(pclk),
		.presetn(presetn),
		.bus_reset(bus_reset_ev),
		.reg_write(wr_gap),
		.reg_value(pwdata[sbp_pkg::GAP_LSB +: 6]),
		.cfg_valid(phy_config_valid),
		.cfg_value(phy_config_gap),
		.gap(arb_gap_setting)
	);

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	// Unset bits stay zero, which covers every reserved field
	always_comb
	begin
		rd = 8'h00; // [R3]
		if (mapped)
		begin
			if (idx[3])
				rd = upper_rsvd ? 8'h00 : paged_rdata; // [R4]
			else
			begin
				unique case (idx)
					sbp_pkg::IDX_NODE:
					begin
						rd[sbp_pkg::NODE_ADDR_LSB +: 6] = cur.node_address; // [R5]
						rd[sbp_pkg::ROOT_POS] = cur.top_node;
						rd[sbp_pkg::CPS_POS] = cable_power_sense; // [R7]
					end
					sbp_pkg::IDX_GAP:
					begin
						rd[sbp_pkg::RHB_POS] = cur.root_holdoff;
						rd[sbp_pkg::LRR_POS] = cur.long_req;
						rd[sbp_pkg::GAP_LSB +: 6] = arb_gap_setting;
					end
					sbp_pkg::IDX_CAPS:
					begin
						rd[sbp_pkg::EXT_LSB +: 3] = sbp_pkg::EXT_CODE; // [R13]
						rd[sbp_pkg::PORTQ_LSB +: 4] = sbp_pkg::PORT_QTY; // [R14]
					end
					sbp_pkg::IDX_SPEED:
					begin
						rd[sbp_pkg::SPEED_LSB +: 3] = sbp_pkg::SPEED_CODE; // [R15]
						rd[sbp_pkg::DELAY_LSB +: 4] = sbp_pkg::DELAY_CODE; // [R16]
					end
					sbp_pkg::IDX_LINK:
					begin
						rd[sbp_pkg::BOUND_POS] = cur.bound_up;
						rd[sbp_pkg::BID_POS] = cur.bid;
						rd[sbp_pkg::JITTER_LSB +: 3] = sbp_pkg::JITTER_CODE; // [R19]
						rd[sbp_pkg::PWR_LSB +: 3] = cur.pwr;
					end
					sbp_pkg::IDX_IRQ:
					begin
						rd[sbp_pkg::RPIE_POS] = cur.rpie;
						rd[sbp_pkg::SRR_POS] = cur.short_req;
						rd[sbp_pkg::CTOI_POS] = cur.ctoi;
						rd[sbp_pkg::CPSI_POS] = cur.cpsi;
						rd[sbp_pkg::STOI_POS] = cur.stoi;
						rd[sbp_pkg::PEI_POS] = cur.pei;
						rd[sbp_pkg::EAA_POS] = cur.eaa;
						rd[sbp_pkg::EMC_POS] = cur.emc;
					end
					sbp_pkg::IDX_RSVD: rd = 8'h00; // [R3]
					sbp_pkg::IDX_PAGE:
					begin
						rd[sbp_pkg::PAGE_LSB +: 3] = cur.page; // [R2]
						rd[sbp_pkg::PORT_LSB +: 4] = cur.port;
					end
					default: rd = 8'h00;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Hardware events beat software clears; software requests beat bus reset
	always_comb
	begin
		next_cur = cur;
		next_cur.cable_power_status = cable_power_sense;
		next_cur.status_push = 1'b0;
		// Straps are caught on the first edge after reset release
		if (!cur.straps_taken)
		begin
			next_cur.bid = contender_link_on_pin; // [R18]
			next_cur.pwr = power_class_pins;
			next_cur.straps_taken = 1'b1;
		end
		// Bus reset: holdoff, bound-up, bid, page and port are left alone
		if (bus_reset_ev)
		begin
			next_cur.long_req = 1'b0; // [R10]
			next_cur.short_req = 1'b0;
			next_cur.top_node = 1'b0; // [R6]
			next_cur.addr_valid = 1'b0; // [R5]
		end
		if (became_root)
			next_cur.top_node = 1'b1; // [R6]
		if (self_id_done)
		begin
			next_cur.node_address = self_id_address; // [R5]
			next_cur.addr_valid = 1'b1;
			next_cur.status_push = 1'b1;
		end
		// Register writes; read-only fields have no write path
		if (wr_gap)
		begin
			next_cur.root_holdoff = pwdata[sbp_pkg::RHB_POS]; // [R8]
			next_cur.long_req = pwdata[sbp_pkg::LRR_POS]; // [R9]
		end
		if (wr_link)
		begin
			next_cur.bound_up = pwdata[sbp_pkg::BOUND_POS]; // [R17]
			next_cur.bid = pwdata[sbp_pkg::BID_POS]; // [R18]
			next_cur.pwr = pwdata[sbp_pkg::PWR_LSB +: 3]; // [R23]
		end
		if (wr_irq)
		begin
			next_cur.rpie = pwdata[sbp_pkg::RPIE_POS];
			next_cur.short_req = pwdata[sbp_pkg::SRR_POS];
			next_cur.eaa = pwdata[sbp_pkg::EAA_POS];
			next_cur.emc = pwdata[sbp_pkg::EMC_POS];
			if (pwdata[sbp_pkg::CTOI_POS])
				next_cur.ctoi = 1'b0; // [R22]
			if (pwdata[sbp_pkg::CPSI_POS])
				next_cur.cpsi = 1'b0; // [R22]
			if (pwdata[sbp_pkg::STOI_POS])
				next_cur.stoi = 1'b0; // [R22]
			if (pwdata[sbp_pkg::PEI_POS])
				next_cur.pei = 1'b0; // [R22]
		end
		if (wr_page)
		begin
			next_cur.page = pwdata[sbp_pkg::PAGE_LSB +: 3]; // [R20]
			next_cur.port = pwdata[sbp_pkg::PORT_LSB +: 4]; // [R21]
		end
		// Sticky event flags, set after the clears so a set wins
		if (config_timeout_event)
			next_cur.ctoi = 1'b1;
		if (cur.cable_power_status && !cable_power_sense)
			next_cur.cpsi = 1'b1;
		if (state_timeout_event)
			next_cur.stoi = 1'b1;
		if (port_event || (cur.rpie && resume_event))
			next_cur.pei = 1'b1;
		next_cur.link_bit = next_cur.bound_up && link_power_status; // [R17]
		// Read data is captured in the setup cycle and held for access
		if (setup)
		begin
			next_cur.rdata = rd;
			next_cur.slverr = !mapped;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cur <= '0;
			cur.bound_up <= sbp_pkg::BOUND_RESET; // [R17]
			cur.page <= sbp_pkg::PAGE_RESET; // [R20]
			cur.port <= sbp_pkg::PORT_RESET; // [R21]
		end
		else
			cur <= next_cur;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Zero wait states keep the bus simple; data was ready at setup
	assign pready = 1'b1;
	assign prdata = {24'h000000, cur.rdata};
	assign pslverr = psel && penable && cur.slverr;
	assign page_choice = cur.page;
	assign port_choice = cur.port;
	assign node_address_valid = cur.addr_valid;
	assign status_push = cur.status_push;
	assign root_holdoff = cur.root_holdoff;
	assign bus_reset_active = timer_active;
	assign arb_accel_enable = cur.eaa;
	assign multispeed_enable = cur.emc;
	assign self_id_link_bit = cur.link_bit;
	assign self_id_contender = cur.bid;
	assign self_id_power_class = cur.pwr;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_rsvd_page_zero: assert property ( // [R4]
		setup && !pwrite && mapped && upper_rsvd |=> prdata == 32'h0)
		else $error("Reserved page read not zero");
	a_caps_fixed: assert property ( // [R13] [R14]
		setup && !pwrite && mapped && idx == sbp_pkg::IDX_CAPS
		|=> prdata[7:0] == {sbp_pkg::EXT_CODE, 1'b0, sbp_pkg::PORT_QTY})
		else $error("Capability register wrong");
	a_speed_fixed: assert property ( // [R15] [R16]
		setup && !pwrite && mapped && idx == sbp_pkg::IDX_SPEED
		|=> prdata[7:0] == {sbp_pkg::SPEED_CODE, 1'b0, sbp_pkg::DELAY_CODE})
		else $error("Speed register wrong");
	a_jitter_zero: assert property ( // [R19]
		setup && !pwrite && mapped && idx == sbp_pkg::IDX_LINK
		|=> prdata[5:3] == sbp_pkg::JITTER_CODE)
		else $error("Jitter field not zero");
	a_cps_tracks: assert property ( // [R7]
		setup && !pwrite && mapped && idx == sbp_pkg::IDX_NODE
		|=> prdata[sbp_pkg::CPS_POS] == $past(cable_power_sense))
		else $error("Cable power bit stale");
	a_launch_waits: assert property ( // [R9]
		$rose(bus_reset_active) |-> $past(!link_busy) && $past(cur.long_req || cur.short_req))
		else $error("Reset launched during traffic");
	a_long_holds: assert property ( // [R9]
		launch_long |=> bus_reset_active [*8])
		else $error("Long reset ended early");
	a_req_cleared: assert property ( // [R10]
		bus_reset_in && !wr_gap |=> !cur.long_req)
		else $error("Long request survived bus reset");
	a_holdoff_kept: assert property ( // [R8]
		bus_reset_in && !wr_gap |=> $stable(root_holdoff))
		else $error("Holdoff changed by bus reset");
	a_gap_written: assert property ( // [R11]
		wr_gap |=> arb_gap_setting == $past(pwdata[5:0]))
		else $error("Gap write not applied");
	a_root_cleared: assert property ( // [R6]
		bus_reset_ev && !became_root |=> !cur.top_node)
		else $error("Root flag survived bus reset");
	a_flag_w1c: assert property ( // [R22]
		wr_irq && pwdata[sbp_pkg::CTOI_POS] && !config_timeout_event |=> !cur.ctoi)
		else $error("Timeout flag not cleared");
	a_node_ro: assert property ( // [R23]
		wr_ok && idx == sbp_pkg::IDX_NODE && !self_id_done |=> $stable(cur.node_address))
		else $error("Read-only node address written");

	c_long_reset: cover property (launch_long ##1 bus_reset_active);
	c_self_id: cover property (bus_reset_in ##[1:20] self_id_done);
	c_rsvd_read: cover property (setup && !pwrite && upper_rsvd);
endmodule

// [verilog/sbp_gap_tracker.sv]
module sbp_gap_tracker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bus_reset,
	input wire logic reg_write,
	input wire logic [5:0] reg_value,
	input wire logic cfg_valid,
	input wire logic [5:0] cfg_value,
	output logic [5:0] gap
);
	typedef struct packed {
		logic [5:0] gap;
		logic one_reset_seen;
	} sbp_gap_t;

	sbp_gap_t cur;
	sbp_gap_t next_cur;

	// An update restarts the pair count; the register write beats a packet
	always_comb
	begin
		next_cur = cur;
		if (reg_write)
		begin
			next_cur.gap = reg_value; // [R11]
			next_cur.one_reset_seen = 1'b0;
		end
		else if (cfg_valid)
		begin
			next_cur.gap = cfg_value; // [R11]
			next_cur.one_reset_seen = 1'b0;
		end
		else if (bus_reset)
		begin
			if (cur.one_reset_seen)
			begin
				next_cur.gap = sbp_pkg::GAP_RESET; // [R12]
				next_cur.one_reset_seen = 1'b0;
			end
			else
				next_cur.one_reset_seen = 1'b1;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cur <= '{gap: sbp_pkg::GAP_RESET, one_reset_seen: 1'b0}; // [R12]
		else
			cur <= next_cur;
	end

	assign gap = cur.gap;
endmodule

// [verilog/sbp_pkg.sv]
package sbp_pkg;
	// ------------------------------------------------------------
	// Register map: word index, byte address is four times it
	// ------------------------------------------------------------
	localparam int REG_COUNT = 16;
	localparam logic [3:0] IDX_NODE = 4'h0;
	localparam logic [3:0] IDX_GAP = 4'h1;
	localparam logic [3:0] IDX_CAPS = 4'h2;
	localparam logic [3:0] IDX_SPEED = 4'h3;
	localparam logic [3:0] IDX_LINK = 4'h4;
	localparam logic [3:0] IDX_IRQ = 4'h5;
	localparam logic [3:0] IDX_RSVD = 4'h6;
	localparam logic [3:0] IDX_PAGE = 4'h7;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int NODE_ADDR_LSB = 2;
	localparam int ROOT_POS = 1;
	localparam int CPS_POS = 0;
	localparam int RHB_POS = 7;
	localparam int LRR_POS = 6;
	localparam int GAP_LSB = 0;
	localparam int EXT_LSB = 5;
	localparam int PORTQ_LSB = 0;
	localparam int SPEED_LSB = 5;
	localparam int DELAY_LSB = 0;
	localparam int BOUND_POS = 7;
	localparam int BID_POS = 6;
	localparam int JITTER_LSB = 3;
	localparam int PWR_LSB = 0;
	localparam int RPIE_POS = 7;
	localparam int SRR_POS = 6;
	localparam int CTOI_POS = 5;
	localparam int CPSI_POS = 4;
	localparam int STOI_POS = 3;
	localparam int PEI_POS = 2;
	localparam int EAA_POS = 1;
	localparam int EMC_POS = 0;
	localparam int PAGE_LSB = 5;
	localparam int PORT_LSB = 0;

	// ------------------------------------------------------------
	// Fixed codes and reset values
	// ------------------------------------------------------------
	localparam logic [2:0] EXT_CODE = 3'h7;
	localparam logic [3:0] PORT_QTY = 4'h3;
	localparam logic [2:0] SPEED_CODE = 3'h2;
	localparam logic [3:0] DELAY_CODE = 4'h0;
	localparam logic [2:0] JITTER_CODE = 3'h0;
	localparam logic [5:0] GAP_RESET = 6'h3f;
	localparam logic BOUND_RESET = 1'b1;
	localparam logic [2:0] PAGE_RESET = 3'h0;
	localparam logic [3:0] PORT_RESET = 4'h0;
	localparam logic [2:0] RSVD_PAGE_LO = 3'h2;
	localparam logic [2:0] RSVD_PAGE_HI = 3'h6;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int LONG_RESET_NS = 166000;
	localparam int SHORT_RESET_NS = 1300;
	localparam int LONG_RESET_CYCLES = (LONG_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHORT_RESET_CYCLES = (SHORT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0]
	{
		SBP_RST_IDLE = 2'b00,
		SBP_RST_LONG = 2'b01,
		SBP_RST_SHORT = 2'b10
	} sbp_rst_state_t;
endpackage

// [verilog/sbp_reset_timer.sv]
module sbp_reset_timer #(
	parameter int LONG_CYCLES = sbp_pkg::LONG_RESET_CYCLES,
	parameter int SHORT_CYCLES = sbp_pkg::SHORT_RESET_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start_long,
	input wire logic start_short,
	output logic active
);
	localparam int CW = $clog2(LONG_CYCLES + 1);

	generate
		if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES)
		begin : g_bad
			$error("Reset durations must be positive and long not below short");
		end
	endgenerate

	typedef struct packed {
		sbp_pkg::sbp_rst_state_t mode;
		logic [CW-1:0] left;
	} sbp_timer_t;

	sbp_timer_t cur;
	sbp_timer_t next_cur;

	// Count down the drive time; long wins if both start together
	always_comb
	begin
		next_cur = cur;
		unique case (cur.mode)
			sbp_pkg::SBP_RST_IDLE:
			begin
				if (start_long)
				begin
					next_cur.mode = sbp_pkg::SBP_RST_LONG;
					next_cur.left = CW'(LONG_CYCLES - 1);
				end
				else if (start_short)
				begin
					next_cur.mode = sbp_pkg::SBP_RST_SHORT;
					next_cur.left = CW'(SHORT_CYCLES - 1);
				end
			end
			sbp_pkg::SBP_RST_LONG, sbp_pkg::SBP_RST_SHORT:
			begin
				if (cur.left == '0)
					next_cur.mode = sbp_pkg::SBP_RST_IDLE;
				else
					next_cur.left = cur.left - CW'(1);
			end
			default: next_cur.mode = sbp_pkg::SBP_RST_IDLE; // Code 11 is illegal
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cur <= '{mode: sbp_pkg::SBP_RST_IDLE, left: '0};
		else
			cur <= next_cur;
	end

	assign active = (cur.mode != sbp_pkg::SBP_RST_IDLE);
endmodule
